// ==== logic/dbsc_pkg.sv ====
// Shared constants and carriers for the converter buffer and sync control.
// Assumes a single 200 MHz bus clock; the converter clock arrives as a pin.
package dbsc_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_FIRST_CTRL = 8'h00;
    localparam logic [7:0] OFF_SECOND_CTRL = 8'h04;
    localparam logic [7:0] OFF_EVENT_CTRL = 8'h08;
    localparam logic [7:0] OFF_INT_ENABLE = 8'h0C;
    localparam logic [7:0] OFF_INT_FLAG = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [7:0] OFF_SYNC_BUSY = 8'h18;
    localparam logic [7:0] OFF_DATA = 8'h1C;
    localparam logic [7:0] OFF_STAGING = 8'h20;
    // Field positions
    localparam int BIT_SOFT_RESET = 0;
    localparam int BIT_ENABLE = 1;
    localparam int BIT_DITHER = 2;
    localparam int BIT_INT_OUT = 0;
    localparam int BIT_EXT_OUT = 1;
    localparam int BIT_PUMP_DIS = 2;
    localparam int BIT_START_IN = 0;
    localparam int BIT_EMPTY_OUT = 1;
    localparam int BIT_UNDERRUN = 0;
    localparam int BIT_EMPTY = 1;
    localparam int BIT_SYNC_ERR = 2;
    // Reset values
    localparam logic [2:0] RST_FIRST_CTRL = 3'h0;
    localparam logic [2:0] RST_SECOND_CTRL = 3'h0;
    localparam logic [1:0] RST_EVENT_CTRL = 2'h0;
    localparam logic [2:0] RST_INT_ENABLE = 3'h0;
    localparam logic [15:0] RST_DATA = 16'h0000;
    // Timing and sizes
    localparam int SYNC_STAGES = 3;
    localparam logic [3:0] DITHER_LAST = 4'hF;
    localparam int CODE_W = 10;
    localparam int DATA_W = 16;

    typedef struct packed {
        logic [CODE_W-1:0] code;
        logic int_out;
        logic ext_out;
        logic pump_on;
    } dbsc_analog_t;
endpackage

// ==== logic/dbsc_sync.sv ====
// Three-flop synchroniser for a level from another clock domain.
// Assumes the input is a plain level; output changes once stages 2 and 3 agree.
`timescale 1ns/1ps
module dbsc_sync (
    input wire logic clk_i, // Bus clock
    input wire logic rst_i, // Synchronous reset, high
    input wire logic d_i,   // Asynchronous level
    output logic q_o        // Filtered level
);
    logic [2:0] stage_reg;

    // Shift chain; first stage only feeds the second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stage_reg <= 3'h0;
        end else begin
            stage_reg <= {stage_reg[1:0], d_i};
        end
    end

    // Accept a change only when the later stages agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_o <= 1'b0;
        end else if (stage_reg[1] == stage_reg[2]) begin
            q_o <= stage_reg[2];
        end
    end
endmodule

// ==== logic/dbsc_top.sv ====
// Converter buffer and sync control: Wishbone slave, two-stage data queue,
// dithering, events, pump and output routing. Assumes the converter clock
// and low-voltage flag are asynchronous pins; security bits come from the bus.
//
// Register access over Wishbone and the address map were chosen for this implementation.
`timescale 1ns/1ps
module dbsc_top (
    input wire logic clk_i,              // Bus clock 200 MHz
    input wire logic rst_i,              // Synchronous reset, high
    input wire logic wb_cyc_i,           // Wishbone cycle
    input wire logic wb_stb_i,           // Wishbone strobe
    input wire logic wb_we_i,            // Write enable
    input wire logic [7:0] wb_adr_i,     // Byte address
    input wire logic [3:0] wb_sel_i,     // Byte selects
    input wire logic [31:0] wb_dat_i,    // Write data
    output logic [31:0] wb_dat_o,        // Read data
    output logic wb_ack_o,               // Acknowledge
    input wire logic secure_access_i,    // Master is secure
    input wire logic periph_secure_i,    // Block attributed secure
    output logic access_error_o,         // Access controller error pulse
    input wire logic start_event_i,      // Start-conversion event pulse
    input wire logic low_voltage_i,      // Supply below pump threshold, async
    input wire logic conv_clk_i,         // Converter clock level, async
    output logic empty_event_o,          // Buffer-empty event pulse
    output logic dma_req_o,              // Buffer-empty DMA request pulse
    output logic underrun_irq_o,         // Underrun request level
    output logic empty_irq_o,            // Empty request level
    output dbsc_pkg::dbsc_analog_t analog_o // Code and analog controls
);
    logic [2:0] first_control_reg;
    logic [2:0] second_control_reg;
    logic [1:0] event_control_reg;
    logic [2:0] int_enable_reg;
    logic [2:0] int_flag_reg;
    logic [15:0] data_reg;
    logic [15:0] staging_buffer_reg;
    logic staging_full_reg;
    logic [3:0] sub_count_reg;
    logic [2:0] busy_reg;
    logic low_volt_sync;
    logic conv_sync;
    logic conv_tick_reg;
    logic bus_req;
    logic allowed;
    logic wr_ok;
    logic start_fire;
    logic transfer;
    logic empty_pulse;
    logic data_wr;
    logic stage_wr;
    logic ctrl_wr;
    logic sync_err;
    logic [31:0] rd_word;

    // Supply level comes from another domain
    dbsc_sync u_lv_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(low_voltage_i),
        .q_o(low_volt_sync)
    );
    // Converter clock used as a slow tick to finish synchronization
    dbsc_sync u_cc_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(conv_clk_i),
        .q_o(conv_sync)
    );
    function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
        hit = (adr == off);
    endfunction
    assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign allowed = !periph_secure_i || secure_access_i;
    assign wr_ok = bus_req && wb_we_i && allowed && wb_sel_i[0];
    assign ctrl_wr = wr_ok && hit(wb_adr_i, dbsc_pkg::OFF_FIRST_CTRL);
    assign data_wr = wr_ok && hit(wb_adr_i, dbsc_pkg::OFF_DATA);
    assign stage_wr = wr_ok && hit(wb_adr_i, dbsc_pkg::OFF_STAGING);
    // a write to a busy synchronized field is refused
    assign sync_err = (ctrl_wr && (busy_reg[0] || busy_reg[1]))
        || (data_wr && busy_reg[2]) || (stage_wr && busy_reg[2]);
    // one-cycle ack; a dropped non-secure access also pulses the error
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            access_error_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req;
            access_error_o <= bus_req && !allowed;
        end
    end

    // Rising edge of converter clock marks a sync completion point
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            conv_tick_reg <= 1'b0;
        end else begin
            conv_tick_reg <= conv_sync;
        end
    end

    // busy bits set on write (bit 0 only when soft reset is written), cleared at next converter edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_reg <= 3'h0;
        end else begin
            if (conv_sync && !conv_tick_reg) begin
                busy_reg <= 3'h0;
            end
            if (ctrl_wr && !sync_err) begin
                busy_reg[0] <= wb_dat_i[dbsc_pkg::BIT_SOFT_RESET];
                busy_reg[1] <= 1'b1;
            end
            if ((data_wr || stage_wr) && !sync_err) begin
                busy_reg[2] <= 1'b1;
            end
        end
    end

    // enable and soft reset; soft reset clears control state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            first_control_reg <= dbsc_pkg::RST_FIRST_CTRL;
        end else if (first_control_reg[dbsc_pkg::BIT_SOFT_RESET]) begin
            first_control_reg <= dbsc_pkg::RST_FIRST_CTRL;
        end else if (ctrl_wr && !sync_err) begin
            first_control_reg <= wb_dat_i[2:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || first_control_reg[dbsc_pkg::BIT_SOFT_RESET]) begin
            second_control_reg <= dbsc_pkg::RST_SECOND_CTRL;
        end else if (wr_ok && hit(wb_adr_i, dbsc_pkg::OFF_SECOND_CTRL)) begin
            second_control_reg <= wb_dat_i[2:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || first_control_reg[dbsc_pkg::BIT_SOFT_RESET]) begin
            event_control_reg <= dbsc_pkg::RST_EVENT_CTRL;
        end else if (wr_ok && hit(wb_adr_i, dbsc_pkg::OFF_EVENT_CTRL)
            && !first_control_reg[dbsc_pkg::BIT_ENABLE]) begin
            event_control_reg <= wb_dat_i[1:0];
        end
    end

    // Interrupt enables
    always_ff @(posedge clk_i) begin
        if (rst_i || first_control_reg[dbsc_pkg::BIT_SOFT_RESET]) begin
            int_enable_reg <= dbsc_pkg::RST_INT_ENABLE;
        end else if (wr_ok && hit(wb_adr_i, dbsc_pkg::OFF_INT_ENABLE)) begin
            int_enable_reg <= wb_dat_i[2:0];
        end
    end
    // start honoured only when enabled and input bit set
    assign start_fire = start_event_i && first_control_reg[dbsc_pkg::BIT_ENABLE]
        && event_control_reg[dbsc_pkg::BIT_START_IN];
    // dithering moves the buffer only on the sixteenth start
    assign transfer = start_fire && staging_full_reg && (!first_control_reg[dbsc_pkg::BIT_DITHER]
        || sub_count_reg == dbsc_pkg::DITHER_LAST);
    // sub-conversion counter runs on each start while dithering, held at zero otherwise
    always_ff @(posedge clk_i) begin
        if (rst_i || !first_control_reg[dbsc_pkg::BIT_DITHER]) begin
            sub_count_reg <= 4'h0;
        end else if (start_fire) begin
            sub_count_reg <= sub_count_reg + 4'h1;
        end
    end

    // staging buffer fills on write, drains on transfer
    always_ff @(posedge clk_i) begin
        if (rst_i || first_control_reg[dbsc_pkg::BIT_SOFT_RESET]) begin
            staging_buffer_reg <= dbsc_pkg::RST_DATA;
            staging_full_reg <= 1'b0;
        end else if (stage_wr && !sync_err) begin
            staging_buffer_reg <= wb_dat_i[15:0];
            staging_full_reg <= 1'b1;
        end else if (transfer) begin
            staging_full_reg <= 1'b0;
        end
    end

    // data register loads from a bus write or the queue, else keeps value
    always_ff @(posedge clk_i) begin
        if (rst_i || first_control_reg[dbsc_pkg::BIT_SOFT_RESET]) begin
            data_reg <= dbsc_pkg::RST_DATA;
        end else if (data_wr && !sync_err) begin
            data_reg <= wb_dat_i[15:0];
        end else if (transfer) begin
            data_reg <= staging_buffer_reg;
        end
    end
    assign empty_pulse = transfer;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            empty_event_o <= 1'b0;
            dma_req_o <= 1'b0;
        end else begin
            empty_event_o <= empty_pulse && event_control_reg[dbsc_pkg::BIT_EMPTY_OUT];
            dma_req_o <= empty_pulse;
        end
    end

    // sticky flags, set wins over write-one clear
    always_ff @(posedge clk_i) begin
        if (rst_i || first_control_reg[dbsc_pkg::BIT_SOFT_RESET]) begin
            int_flag_reg <= 3'h0;
        end else begin
            if (wr_ok && hit(wb_adr_i, dbsc_pkg::OFF_INT_FLAG)) begin
                int_flag_reg <= int_flag_reg & ~wb_dat_i[2:0];
            end
            if (start_fire && !staging_full_reg) begin
                int_flag_reg[dbsc_pkg::BIT_UNDERRUN] <= 1'b1;
            end
            if (empty_pulse) begin
                int_flag_reg[dbsc_pkg::BIT_EMPTY] <= 1'b1;
            end
            if (sync_err) begin
                int_flag_reg[dbsc_pkg::BIT_SYNC_ERR] <= 1'b1;
            end
        end
    end
    assign underrun_irq_o = int_flag_reg[dbsc_pkg::BIT_UNDERRUN]
        && int_enable_reg[dbsc_pkg::BIT_UNDERRUN];
    assign empty_irq_o = int_flag_reg[dbsc_pkg::BIT_EMPTY] && int_enable_reg[dbsc_pkg::BIT_EMPTY];
    // analog outputs; dither adds one for low sub-steps
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            analog_o <= '0;
        end else begin
            if (first_control_reg[dbsc_pkg::BIT_DITHER] && sub_count_reg < data_reg[3:0]
                && data_reg[13:4] != 10'h3FF) begin
                analog_o.code <= data_reg[13:4] + 10'h001;
            end else if (first_control_reg[dbsc_pkg::BIT_DITHER]) begin
                analog_o.code <= data_reg[13:4];
            end else begin
                analog_o.code <= data_reg[9:0];
            end
            analog_o.int_out <= second_control_reg[dbsc_pkg::BIT_INT_OUT]
                && first_control_reg[dbsc_pkg::BIT_ENABLE];
            analog_o.ext_out <= second_control_reg[dbsc_pkg::BIT_EXT_OUT]
                && first_control_reg[dbsc_pkg::BIT_ENABLE];
            analog_o.pump_on <= low_volt_sync && first_control_reg[dbsc_pkg::BIT_ENABLE]
                && !second_control_reg[dbsc_pkg::BIT_PUMP_DIS];
        end
    end

    // Read mux; reads need no synchronization
    always_comb begin
        rd_word = 32'h00000000;
        unique case (wb_adr_i)
            dbsc_pkg::OFF_FIRST_CTRL: rd_word = {29'h0, first_control_reg};
            dbsc_pkg::OFF_SECOND_CTRL: rd_word = {29'h0, second_control_reg};
            dbsc_pkg::OFF_EVENT_CTRL: rd_word = {30'h0, event_control_reg};
            dbsc_pkg::OFF_INT_ENABLE: rd_word = {29'h0, int_enable_reg};
            dbsc_pkg::OFF_INT_FLAG: rd_word = {29'h0, int_flag_reg};
            dbsc_pkg::OFF_STATUS: rd_word = {30'h0, low_volt_sync, staging_full_reg};
            dbsc_pkg::OFF_SYNC_BUSY: rd_word = {29'h0, busy_reg};
            dbsc_pkg::OFF_DATA: rd_word = {16'h0, data_reg};
            dbsc_pkg::OFF_STAGING: rd_word = {16'h0, staging_buffer_reg};
            default: rd_word = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h00000000;
        end else if (bus_req && !wb_we_i) begin
            wb_dat_o <= allowed ? rd_word : 32'h00000000;
        end
    end
    a_nonsec_denied: assert property (@(posedge clk_i) disable iff (rst_i)
        bus_req && !allowed && !wb_we_i |=> wb_ack_o && access_error_o && wb_dat_o == 32'h0)
        else $error("non-secure read not denied");
    a_open_access: assert property (@(posedge clk_i) disable iff (rst_i)
        bus_req && !periph_secure_i |=> !access_error_o)
        else $error("open access flagged");
    a_evctl_locked: assert property (@(posedge clk_i) disable iff (rst_i)
        first_control_reg[dbsc_pkg::BIT_ENABLE] && !first_control_reg[0]
        |=> $stable(event_control_reg) || $past(first_control_reg[0]))
        else $error("event control changed while enabled");
    a_enable_write: assert property (@(posedge clk_i) disable iff (rst_i)
        ctrl_wr && !sync_err && !first_control_reg[0]
        |=> first_control_reg[dbsc_pkg::BIT_ENABLE] == $past(wb_dat_i[1]))
        else $error("enable not taken");
    a_busy_refuse: assert property (@(posedge clk_i) disable iff (rst_i)
        data_wr && busy_reg[2] && !first_control_reg[0] && !transfer
        |=> $stable(data_reg) && int_flag_reg[dbsc_pkg::BIT_SYNC_ERR])
        else $error("busy write not refused");
    a_start_gate: assert property (@(posedge clk_i) disable iff (rst_i)
        !event_control_reg[dbsc_pkg::BIT_START_IN] |-> !transfer)
        else $error("start taken while disabled");
    sequence s_underrun;
        start_fire && !staging_full_reg && !first_control_reg[0];
    endsequence
    a_underrun_flag: assert property (@(posedge clk_i) disable iff (rst_i)
        s_underrun |=> int_flag_reg[dbsc_pkg::BIT_UNDERRUN])
        else $error("underrun not flagged");
    a_underrun_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        (s_underrun and !data_wr) |=> $stable(data_reg))
        else $error("data changed on underrun");
    a_empty_event: assert property (@(posedge clk_i) disable iff (rst_i)
        transfer && event_control_reg[1]
        |=> empty_event_o ##1 (!empty_event_o || $past(transfer)))
        else $error("empty event missing");
    a_dither_spacing: assert property (@(posedge clk_i) disable iff (rst_i)
        first_control_reg[dbsc_pkg::BIT_DITHER] && transfer
        |-> sub_count_reg == dbsc_pkg::DITHER_LAST)
        else $error("dither transfer off sixteen");
    a_pump_forced: assert property (@(posedge clk_i) disable iff (rst_i)
        second_control_reg[dbsc_pkg::BIT_PUMP_DIS] |=> !analog_o.pump_on)
        else $error("pump not forced off");
endmodule

// ==== sim/testbench.sv ====
// Self-checking bench for the converter buffer and sync control block.
// Assumes the design answers each Wishbone request with a one-cycle ack.
`timescale 1ns/1ps
module testbench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd, seed = 32'h13C9;
    logic wb_ack_o, access_error_o, empty_event_o, dma_req_o, underrun_irq_o, empty_irq_o;
    logic secure_access_i = 1'b0, periph_secure_i = 1'b0, start_event_i = 1'b0;
    logic low_voltage_i = 1'b0, conv_clk_i = 1'b0, conv_run = 1'b1;
    logic [1:0] conv_div = 2'h0;
    dbsc_pkg::dbsc_analog_t analog_o;
    int err_total, checks_done, emp_cnt, dma_cnt, acc_cnt, exp_emp, plus, m_data, d, base;
    int q[$];

    dbsc_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .secure_access_i(secure_access_i),
        .periph_secure_i(periph_secure_i), .access_error_o(access_error_o),
        .start_event_i(start_event_i), .low_voltage_i(low_voltage_i), .conv_clk_i(conv_clk_i),
        .empty_event_o(empty_event_o), .dma_req_o(dma_req_o), .underrun_irq_o(underrun_irq_o),
        .empty_irq_o(empty_irq_o), .analog_o(analog_o));

    // Bus clock, 5 ns period
    always #2.5 clk_i = ~clk_i;

    // Converter clock at one eighth of the bus rate; can be frozen to hold busy bits
    always @(posedge clk_i) begin
        conv_div <= conv_div + 2'h1;
        if (!conv_run) begin
            conv_clk_i <= 1'b0;
        end else if (conv_div == 2'h3) begin
            conv_clk_i <= ~conv_clk_i;
        end
    end

    // Pulse counters, so short pulses are never missed by a late look
    always @(posedge clk_i) begin
        if (!rst_i) begin
            emp_cnt <= emp_cnt + int'(empty_event_o === 1'b1);
            dma_cnt <= dma_cnt + int'(dma_req_o === 1'b1);
            acc_cnt <= acc_cnt + int'(access_error_o === 1'b1);
        end
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask

    // One classic cycle; read data lands in rd at the ack edge
    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        // Wait for the answer however long; only the watchdog ends a hang
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        wb_cycle(1'b1, adr, dat);
    endtask

    task automatic rdc(input logic [7:0] adr);
        wb_cycle(1'b0, adr, 32'h0);
    endtask

    // Polls sync busy; a second write before it clears would be dropped
    task automatic wait_sync;
        int n;
        n = 0;
        do begin
            rdc(dbsc_pkg::OFF_SYNC_BUSY);
            n++;
        end while (rd !== 32'h0 && n < 100);
        // A busy bit that never clears counts as a mismatch
        if (rd !== 32'h0) begin
            err_total++;
        end
    endtask

    task automatic load(input int v);
        wr(dbsc_pkg::OFF_STAGING, v);
        wait_sync();
        q.push_back(v);
    endtask

    // starts 34 cycles apart, over four converter clock periods
    task automatic start_pulse;
        @(posedge clk_i);
        start_event_i <= 1'b1;
        @(posedge clk_i);
        start_event_i <= 1'b0;
        repeat (32) @(posedge clk_i);
    endtask

    // Queue model: a start moves staging into data or leaves data alone
    task automatic model_start;
        if (q.size() > 0) begin
            m_data = q.pop_front();
            exp_emp++;
        end
    endtask

    task automatic stop_test;
        $display("mismatches %0d checks %0d", err_total, checks_done);
        if (err_total == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Watchdog well beyond the expected run length
    initial begin
        #200000;
        err_total++;
        stop_test();
    end

    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(dbsc_pkg::OFF_FIRST_CTRL);
        check(rd, 32'h0);
        rdc(8'hFC);
        check(rd, 32'h0);
        periph_secure_i <= 1'b1;
        wr(dbsc_pkg::OFF_EVENT_CTRL, 32'h2);
        rdc(dbsc_pkg::OFF_EVENT_CTRL);
        check(rd, 32'h0);
        secure_access_i <= 1'b1;
        rdc(dbsc_pkg::OFF_EVENT_CTRL);
        check(rd, 32'h0);
        check(acc_cnt, 32'h2);
        periph_secure_i <= 1'b0;
        secure_access_i <= 1'b0;
        wr(dbsc_pkg::OFF_EVENT_CTRL, 32'h2);
        rdc(dbsc_pkg::OFF_EVENT_CTRL);
        check(rd, 32'h2);
        wr(dbsc_pkg::OFF_INT_ENABLE, 32'h3);
        conv_run <= 1'b0;
        // Let a converter edge already in the synchroniser drain first
        repeat (8) @(posedge clk_i);
        wr(dbsc_pkg::OFF_FIRST_CTRL, 32'h2);
        wr(dbsc_pkg::OFF_FIRST_CTRL, 32'h0);
        wr(dbsc_pkg::OFF_DATA, 32'h5);
        wr(dbsc_pkg::OFF_DATA, 32'h6);
        rdc(dbsc_pkg::OFF_INT_FLAG);
        check(rd & 32'h4, 32'h4);
        conv_run <= 1'b1;
        wait_sync();
        rdc(dbsc_pkg::OFF_FIRST_CTRL);
        check(rd, 32'h2);
        rdc(dbsc_pkg::OFF_DATA);
        check(rd, 32'h5);
        wr(dbsc_pkg::OFF_EVENT_CTRL, 32'h3);
        rdc(dbsc_pkg::OFF_EVENT_CTRL);
        check(rd, 32'h2);
        seed = lfsr(seed);
        load(seed & 32'h3FF);
        start_pulse();
        rdc(dbsc_pkg::OFF_STATUS);
        check(rd, 32'h1);
        rdc(dbsc_pkg::OFF_DATA);
        check(rd, 32'h5);
        wr(dbsc_pkg::OFF_FIRST_CTRL, 32'h0);
        wait_sync();
        wr(dbsc_pkg::OFF_EVENT_CTRL, 32'h3);
        wr(dbsc_pkg::OFF_FIRST_CTRL, 32'h2);
        wait_sync();
        for (int i = 0; i < 3; i++) begin
            wr(dbsc_pkg::OFF_INT_FLAG, 32'h7);
            if (i > 0) begin
                seed = lfsr(seed);
                load(seed & 32'h3FF);
            end
            start_pulse();
            model_start();
            rdc(dbsc_pkg::OFF_DATA);
            check(rd, m_data);
            check({22'h0, analog_o.code}, m_data & 32'h3FF);
            check(empty_irq_o, 1'b1);
            check(emp_cnt, exp_emp);
            check(dma_cnt, exp_emp);
        end
        wr(dbsc_pkg::OFF_INT_FLAG, 32'h7);
        start_pulse();
        model_start();
        check(underrun_irq_o, 1'b1);
        check(empty_irq_o, 1'b0);
        rdc(dbsc_pkg::OFF_DATA);
        check(rd, m_data);
        wr(dbsc_pkg::OFF_FIRST_CTRL, 32'h6);
        wait_sync();
        seed = lfsr(seed);
        d = seed & 32'h1FFF;
        wr(dbsc_pkg::OFF_DATA, d);
        wait_sync();
        plus = 0;
        for (int i = 0; i < 16; i++) begin
            start_pulse();
            if (analog_o.code === 10'((d >> 4) + 1)) begin
                plus++;
            end else begin
                check({22'h0, analog_o.code}, (d >> 4) & 32'h3FF);
            end
        end
        check(plus, d & 32'hF);
        seed = lfsr(seed);
        d = seed & 32'h1FFF;
        load(d);
        base = dma_cnt;
        // sixteen starts for each buffered sample
        for (int i = 0; i < 16; i++) begin
            start_pulse();
        end
        model_start();
        check(dma_cnt - base, 32'h1);
        check(emp_cnt, exp_emp);
        rdc(dbsc_pkg::OFF_DATA);
        check(rd, m_data);
        // output buffer on together with the internal route
        wr(dbsc_pkg::OFF_SECOND_CTRL, 32'h3);
        low_voltage_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        check({analog_o.int_out, analog_o.ext_out}, 2'b11);
        check(analog_o.pump_on, 1'b1);
        wr(dbsc_pkg::OFF_SECOND_CTRL, 32'h5);
        repeat (3) @(posedge clk_i);
        check(analog_o.pump_on, 1'b0);
        wr(dbsc_pkg::OFF_FIRST_CTRL, 32'h1);
        wait_sync();
        rdc(dbsc_pkg::OFF_EVENT_CTRL);
        check(rd, 32'h0);
        rdc(dbsc_pkg::OFF_DATA);
        check(rd, 32'h0);
        stop_test();
    end
endmodule
